/* common/pft_regs.svh */
// Purpose: register map, field positions and timing figures of the pulse flow totalizer
// Assumes: 32-bit APB data, one aligned word per register
// Notes: definitions only
`ifndef PFT_REGS_SVH
`define PFT_REGS_SVH

`define PFT_CLK_HZ 50000000
`define PFT_MS_PER_S 1000
`define PFT_ADDR_W 8

// byte offsets
`define PFT_OFF_CTRL 8'h00
`define PFT_OFF_CMD 8'h04
`define PFT_OFF_LOW 8'h08
`define PFT_OFF_HIGH 8'h0C
`define PFT_OFF_RATE 8'h10
`define PFT_OFF_TOTAL 8'h14
`define PFT_OFF_STS 8'h18
`define PFT_OFF_MASK 8'h1C
`define PFT_OFF_FLAGS 8'h20

// control fields
`define PFT_CTRL_MODE 1:0
`define PFT_CTRL_FLT 5:2
`define PFT_CTRL_ZT 7:6
`define PFT_CTRL_TB 9:8
`define PFT_CTRL_RSTEN 10
`define PFT_CTRL_STBEN 11
`define PFT_CTRL_DIREN 12
`define PFT_CMD_RESET 0

// status, mask and live flag bits
`define PFT_STS_W 4
`define PFT_STS_LO 0
`define PFT_STS_HI 1
`define PFT_STS_ZERO 2
`define PFT_STS_CLR 3
`define PFT_FLG_DIR 2

// filter limits in hertz, selector 0 disables the filter
`define PFT_FLT_HZ_1 10
`define PFT_FLT_HZ_2 25
`define PFT_FLT_HZ_3 50
`define PFT_FLT_HZ_4 100
`define PFT_FLT_HZ_5 1000
`define PFT_FLT_HZ_6 5000
`define PFT_FLT_HZ_7 10000
`define PFT_FLT_HZ_8 50000

// zero timeouts, rate gate and time-base factors
`define PFT_ZT_MS_0 100
`define PFT_ZT_MS_1 1000
`define PFT_ZT_MS_2 10000
`define PFT_GATE_MS 1000
`define PFT_TB_MIN 60
`define PFT_TB_HOUR 3600

`endif

/* common/pft_pkg.sv */
// Purpose: types shared by the pulse flow totalizer modules
// Assumes: pft_regs.svh on the include path
// Notes: none
`include "pft_regs.svh"
package pft_pkg;
  typedef logic [31:0] pft_word_t;
  typedef logic [`PFT_ADDR_W-1:0] pft_addr_t;
  typedef enum logic [1:0] {
    PFT_MODE_DIR = 2'h0,
    PFT_MODE_QUAD1 = 2'h1,
    PFT_MODE_QUAD4 = 2'h3
  } pft_mode_t;
  typedef enum logic {
    PFT_RS_ZERO = 1'b0,
    PFT_RS_MEAS = 1'b1
  } pft_rstate_t;
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] clean;
    logic [1:0][31:0] cnt;
  } pft_flt_state_t;
  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] flt_sel;
    logic [1:0] zt_sel;
    logic [1:0] tb_sel;
    logic rst_en;
    logic stb_en;
    logic dir_en;
    pft_word_t low;
    pft_word_t high;
    logic [`PFT_STS_W-1:0] sts;
    logic [`PFT_STS_W-1:0] mask;
    logic pready;
    pft_word_t prdata;
    logic pslverr;
    logic irq;
    logic [1:0] prev_ab;
    logic neg_dir;
    pft_rstate_t rstate;
    pft_word_t gate_cnt;
    pft_word_t idle_cnt;
    pft_word_t win;
    pft_word_t rate;
    pft_word_t total;
    logic lo;
    logic hi;
  } pft_state_t;
endpackage : pft_pkg

/* common/pft_flt_if.sv */
// Purpose: carries the counting inputs through the input filter
// Assumes: single clock domain on the filtered side
// Notes: min_cyc of zero disables filtering
`timescale 1ns/1ps
interface pft_flt_if;
  logic [1:0] raw;
  logic [31:0] min_cyc;
  logic [1:0] clean;
  modport flt (input raw, input min_cyc, output clean);
  modport ctl (output raw, output min_cyc, input clean);
endinterface : pft_flt_if

/* verilog/pft_filter.sv */
// Purpose: synchronises and de-bounces the two counting inputs
// Assumes: raw inputs are asynchronous pins
// Notes: a level must persist min_cyc cycles to be accepted
`timescale 1ns/1ps
module pft_filter (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // filter channel
  pft_flt_if.flt flt
);
  import pft_pkg::*;

  pft_flt_state_t q;
  pft_flt_state_t d;

  always_comb begin
    d = q;
    d.s1 = flt.raw;
    d.s2 = q.s1;
    for (int i = 0; i < 2; i++) begin
      if (q.s2[i] == q.clean[i]) begin
        d.cnt[i] = '0;
      end else if (flt.min_cyc == '0 || q.cnt[i] >= flt.min_cyc - 32'h00000001) begin
        // level held long enough; shorter pulses never get here
        d.clean[i] = q.s2[i];
        d.cnt[i] = '0;
      end else begin
        d.cnt[i] = q.cnt[i] + 32'h00000001;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign flt.clean = q.clean;
endmodule : pft_filter

/* verilog/pft_top.sv */
// Purpose: pulse flowmeter channel: decoder, filter, rate meter and totalizer
// Assumes: APB register access; logical channel values arrive on core_clk_i
// Notes: rate is a net pulse count over a one second gate, scaled by time base
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "pft_regs.svh"

// Function
// - direction mode counts first input rising edges
// - second input low counts up, high down
// - single quadrature counts from phase relation
// - fourfold quadrature gives higher resolution
// - filter gives highest accepted input frequency
// - eight selectable filter limits per channel
// - filter disabled means no frequency limit
// - rate forced zero after pulse timeout
// - rate per second, minute or hour
// - low flag, total still accumulates
// - high flag, total still accumulates
// - manual reset clears totalizer
// - positive reset channel clears totalizer
// - strobe nonpositive holds accumulation
// - strobe hold keeps total, rate meter keeps running
// - positive direction channel reverses totalizer
// - totalizer sums pulses, not the integrated rate
module pft_top #(
  parameter int unsigned CLK_HZ = `PFT_CLK_HZ
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire pft_pkg::pft_addr_t paddr_i,
  input wire pft_pkg::pft_word_t pwdata_i,
  output logic pready_o,
  output pft_pkg::pft_word_t prdata_o,
  output logic pslverr_o,
  // counting input pins
  input wire logic cnt_in1_i,
  input wire logic cnt_in2_i,
  // selected logical channel values
  input wire pft_pkg::pft_word_t rst_src_val_i,
  input wire pft_pkg::pft_word_t strobe_src_val_i,
  input wire pft_pkg::pft_word_t dir_src_val_i,
  // results
  output pft_pkg::pft_word_t rate_o,
  output pft_pkg::pft_word_t total_o,
  output logic lo_o,
  output logic hi_o,
  output logic irq_o
);
  import pft_pkg::*;

  if (CLK_HZ < `PFT_MS_PER_S) begin : g_bad_clk
    $error("CLK_HZ too small for millisecond timing");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helper functions

  function automatic pft_word_t half_per(input longint unsigned clk, input longint unsigned hz);
    longint unsigned c;
    c = (clk + 2 * hz - 1) / (2 * hz);
    if (c < 1) begin
      c = 1;
    end
    return c[31:0];
  endfunction : half_per

  function automatic pft_word_t flt_cyc(input logic [3:0] sel, input longint unsigned clk);
    pft_word_t c;
    c = '0;
    unique case (sel)
      4'h1: c = half_per(clk, `PFT_FLT_HZ_1);
      4'h2: c = half_per(clk, `PFT_FLT_HZ_2);
      4'h3: c = half_per(clk, `PFT_FLT_HZ_3);
      4'h4: c = half_per(clk, `PFT_FLT_HZ_4);
      4'h5: c = half_per(clk, `PFT_FLT_HZ_5);
      4'h6: c = half_per(clk, `PFT_FLT_HZ_6);
      4'h7: c = half_per(clk, `PFT_FLT_HZ_7);
      4'h8: c = half_per(clk, `PFT_FLT_HZ_8);
      default: c = '0;
    endcase
    return c;
  endfunction : flt_cyc

  function automatic pft_word_t ms_cyc(input longint unsigned clk, input longint unsigned ms);
    longint unsigned c;
    c = clk * ms / `PFT_MS_PER_S;
    if (c < 1) begin
      c = 1;
    end
    return c[31:0];
  endfunction : ms_cyc

  function automatic logic [1:0] quad_pos(input logic [1:0] ab);
    // position along the up sequence 00, 10, 11, 01 (a in bit 0)
    return {ab[0], ab[0] ^ ab[1]};
  endfunction : quad_pos

  function automatic logic signed [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
    logic [1:0] diff;
    diff = quad_pos(cur) - quad_pos(prev);
    unique case (diff)
      2'h1: return 2'sh1;
      2'h3: return -2'sh1;
      default: return 2'sh0;
    endcase
  endfunction : quad_step

  function automatic pft_word_t scale_rate(input pft_word_t w, input logic [1:0] tb);
    unique case (tb)
      2'h1: return 32'($signed(w) * `PFT_TB_MIN);
      2'h2: return 32'($signed(w) * `PFT_TB_HOUR);
      default: return w;
    endcase
  endfunction : scale_rate

  localparam pft_word_t GATE_CYC = ms_cyc(CLK_HZ, `PFT_GATE_MS);
  localparam pft_word_t ZT0_CYC = ms_cyc(CLK_HZ, `PFT_ZT_MS_0);
  localparam pft_word_t ZT1_CYC = ms_cyc(CLK_HZ, `PFT_ZT_MS_1);
  localparam pft_word_t ZT2_CYC = ms_cyc(CLK_HZ, `PFT_ZT_MS_2);

  ////////////////////////////////////////////////////////////////////////////////
  // state and filter

  pft_state_t q;
  pft_state_t d;
  pft_flt_if flt_if ();

  assign flt_if.raw = {cnt_in2_i, cnt_in1_i};
  assign flt_if.min_cyc = flt_cyc(q.flt_sel, CLK_HZ);

  pft_filter u_filter (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .flt(flt_if.flt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  logic [1:0] ab;
  logic signed [1:0] step;
  logic signed [1:0] tstep;
  logic access;
  logic wr;
  logic hit;
  logic rst_cmd;
  logic clear;
  logic hold;
  logic win_end;
  pft_word_t win_next;
  pft_word_t rd;
  pft_word_t zt_cyc;
  pft_word_t new_rate;
  logic [`PFT_STS_W-1:0] sts_set;
  logic [`PFT_STS_W-1:0] sts_clr;

  always_comb begin
    d = q;
    ab = flt_if.clean;
    step = 2'sh0;
    sts_set = '0;
    sts_clr = '0;
    rst_cmd = 1'b0;
    d.prev_ab = ab;

    // pulse decoding
    unique case (q.mode)
      PFT_MODE_DIR: begin
        if (ab[0] && !q.prev_ab[0]) begin
          step = ab[1] ? -2'sh1 : 2'sh1;
        end
      end
      PFT_MODE_QUAD1: begin
        if (ab[0] && !q.prev_ab[0]) begin
          step = quad_step(q.prev_ab, ab);
        end
      end
      PFT_MODE_QUAD4: begin
        step = quad_step(q.prev_ab, ab);
      end
      default: step = 2'sh0;
    endcase

    // apb decode
    access = psel_i && penable_i;
    wr = access && q.pready && pwrite_i;
    hit = 1'b1;
    rd = '0;
    unique case (paddr_i)
      `PFT_OFF_CTRL: begin
        rd[`PFT_CTRL_MODE] = q.mode;
        rd[`PFT_CTRL_FLT] = q.flt_sel;
        rd[`PFT_CTRL_ZT] = q.zt_sel;
        rd[`PFT_CTRL_TB] = q.tb_sel;
        rd[`PFT_CTRL_RSTEN] = q.rst_en;
        rd[`PFT_CTRL_STBEN] = q.stb_en;
        rd[`PFT_CTRL_DIREN] = q.dir_en;
      end
      `PFT_OFF_CMD: rd = '0;
      `PFT_OFF_LOW: rd = q.low;
      `PFT_OFF_HIGH: rd = q.high;
      `PFT_OFF_RATE: rd = q.rate;
      `PFT_OFF_TOTAL: rd = q.total;
      `PFT_OFF_STS: rd[`PFT_STS_W-1:0] = q.sts;
      `PFT_OFF_MASK: rd[`PFT_STS_W-1:0] = q.mask;
      `PFT_OFF_FLAGS: begin
        rd[`PFT_STS_LO] = q.lo;
        rd[`PFT_STS_HI] = q.hi;
        rd[`PFT_FLG_DIR] = q.neg_dir;
      end
      default: hit = 1'b0;
    endcase
    d.pready = access && !q.pready;
    if (access && !q.pready) begin
      d.prdata = pwrite_i ? '0 : rd;
      d.pslverr = !hit;
    end

    if (wr && hit) begin
      unique case (paddr_i)
        `PFT_OFF_CTRL: begin
          d.mode = pwdata_i[`PFT_CTRL_MODE];
          d.flt_sel = pwdata_i[`PFT_CTRL_FLT];
          d.zt_sel = pwdata_i[`PFT_CTRL_ZT];
          d.tb_sel = pwdata_i[`PFT_CTRL_TB];
          d.rst_en = pwdata_i[`PFT_CTRL_RSTEN];
          d.stb_en = pwdata_i[`PFT_CTRL_STBEN];
          d.dir_en = pwdata_i[`PFT_CTRL_DIREN];
        end
        `PFT_OFF_CMD: rst_cmd = pwdata_i[`PFT_CMD_RESET];
        `PFT_OFF_LOW: d.low = pwdata_i;
        `PFT_OFF_HIGH: d.high = pwdata_i;
        `PFT_OFF_STS: sts_clr = pwdata_i[`PFT_STS_W-1:0];
        `PFT_OFF_MASK: d.mask = pwdata_i[`PFT_STS_W-1:0];
        default: sts_clr = '0;
      endcase
    end

    // rate meter keeps running whatever the strobe does
    unique case (q.zt_sel)
      2'h0: zt_cyc = ZT0_CYC;
      2'h1: zt_cyc = ZT1_CYC;
      default: zt_cyc = ZT2_CYC;
    endcase
    win_end = q.gate_cnt >= GATE_CYC - 32'h00000001;
    win_next = q.win + 32'(step);
    if (win_end) begin
      d.gate_cnt = '0;
      d.win = '0;
    end else begin
      d.gate_cnt = q.gate_cnt + 32'h00000001;
      d.win = win_next;
    end
    new_rate = q.rate;
    if (win_end) begin
      new_rate = scale_rate(win_next, q.tb_sel);
    end
    unique case (q.rstate)
      PFT_RS_ZERO: begin
        new_rate = '0;
        if (step != 2'sh0) begin
          d.rstate = PFT_RS_MEAS;
          d.idle_cnt = '0;
        end
      end
      PFT_RS_MEAS: begin
        if (step != 2'sh0) begin
          d.idle_cnt = '0;
        end else if (q.idle_cnt >= zt_cyc - 32'h00000001) begin
          d.rstate = PFT_RS_ZERO;
          d.idle_cnt = '0;
          new_rate = '0;
          sts_set[`PFT_STS_ZERO] = 1'b1;
        end else begin
          d.idle_cnt = q.idle_cnt + 32'h00000001;
        end
      end
    endcase
    d.rate = new_rate;
    d.lo = $signed(new_rate) < $signed(q.low);
    d.hi = $signed(new_rate) > $signed(q.high);
    sts_set[`PFT_STS_LO] = d.lo && !q.lo;
    sts_set[`PFT_STS_HI] = d.hi && !q.hi;

    // totalizer, in pulses of the base unit
    d.neg_dir = q.dir_en && ($signed(dir_src_val_i) > 0);
    tstep = q.neg_dir ? -step : step;
    hold = q.stb_en && ($signed(strobe_src_val_i) <= 0);
    clear = rst_cmd || (q.rst_en && ($signed(rst_src_val_i) > 0));
    if (clear) begin
      d.total = '0;
      sts_set[`PFT_STS_CLR] = 1'b1;
    end else if (!hold) begin
      d.total = q.total + 32'(tstep);
    end

    // sticky status: a new event beats a clear in the same cycle
    d.sts = (q.sts & ~sts_clr) | sts_set;
    d.irq = |(d.sts & d.mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pready_o = q.pready;
  assign prdata_o = q.prdata;
  assign pslverr_o = q.pslverr;
  assign rate_o = q.rate;
  assign total_o = q.total;
  assign lo_o = q.lo;
  assign hi_o = q.hi;
  assign irq_o = q.irq;
endmodule : pft_top

/* dv/pft_properties.sv */
// Purpose: port properties of the pulse flow totalizer
// Assumes: bound into pft_top with its CLK_HZ
// Notes: CTRL and LOW are shadowed from APB writes
`timescale 1ns/1ps
`include "pft_regs.svh"
module pft_properties #(
  parameter int unsigned CLK_HZ = 50000000
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire pft_pkg::pft_addr_t paddr_i,
  input wire pft_pkg::pft_word_t pwdata_i,
  input wire logic pready_o,
  input wire pft_pkg::pft_word_t prdata_o,
  input wire logic pslverr_o,
  // pins and channels
  input wire logic cnt_in1_i,
  input wire logic cnt_in2_i,
  input wire pft_pkg::pft_word_t rst_src_val_i,
  input wire pft_pkg::pft_word_t strobe_src_val_i,
  input wire pft_pkg::pft_word_t dir_src_val_i,
  // results
  input wire pft_pkg::pft_word_t rate_o,
  input wire pft_pkg::pft_word_t total_o,
  input wire logic lo_o,
  input wire logic hi_o,
  input wire logic irq_o
);
  import pft_pkg::*;
  localparam int ZT_LIM = CLK_HZ / 10 + 600;
  logic wr;
  logic [1:0] pins_q;
  pft_word_t ctrl_q, low_q, idle_q;
  assign wr = psel_i && penable_i && pwrite_i && pready_o;
  // register shadows and cycles since either pin moved
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= '0;
      low_q <= '0;
      pins_q <= '0;
      idle_q <= '0;
    end else begin
      pins_q <= {cnt_in2_i, cnt_in1_i};
      idle_q <= (pins_q != {cnt_in2_i, cnt_in1_i}) ? '0 : idle_q + 32'h1;
      if (wr && paddr_i == `PFT_OFF_CTRL) ctrl_q <= pwdata_i;
      if (wr && paddr_i == `PFT_OFF_LOW) low_q <= pwdata_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_rdy_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");
  property p_unmapped;
    psel_i && penable_i && !pready_o && paddr_i > `PFT_OFF_FLAGS |=> pslverr_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  property p_cmd_clear;
    wr && paddr_i == `PFT_OFF_CMD && pwdata_i[0] |-> ##[1:3] total_o == '0;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("total not cleared");
  property p_chan_clear;
    (ctrl_q[10] && $signed(rst_src_val_i) > 0) [*3] |-> total_o == '0;
  endproperty
  a_chan_clear: assert property (p_chan_clear) else $error("channel clear lost");
  property p_hold;
    (ctrl_q[11] && !ctrl_q[10] && $signed(strobe_src_val_i) <= 0 && !wr) [*3] |-> $stable(total_o);
  endproperty
  a_hold: assert property (p_hold) else $error("total moved in hold");
  property p_quiet;
    (idle_q > 600 && !wr && !ctrl_q[10]) [*3] |-> $stable(total_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("total moved without pulses");
  property p_zero;
    ctrl_q[7:6] == 2'h0 && idle_q > ZT_LIM |-> rate_o == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("rate not forced to zero");
  property p_lo;
    ($stable(rate_o) && $stable(low_q)) [*2] |-> lo_o == ($signed(rate_o) < $signed(low_q));
  endproperty
  a_lo: assert property (p_lo) else $error("low flag wrong");
endmodule : pft_properties

/* dv/pft_sensor.sv */
// Purpose: pulse flow sensor driving the two counting pins
// Assumes: pins change just after a rising clock edge
// Notes: pins keep their last level between bursts, as a pulse output does
`timescale 1ns/1ps
module pft_sensor (
  // clock
  input wire logic core_clk_i,
  // counting pins
  output logic cnt_in1_o,
  output logic cnt_in2_o
);
  initial begin
    cnt_in1_o = 1'b0;
    cnt_in2_o = 1'b0;
  end
  task automatic put(input logic a, input logic b, input int hold);
    @(posedge core_clk_i);
    cnt_in1_o <= a;
    cnt_in2_o <= b;
    repeat (hold - 1) @(posedge core_clk_i);
  endtask : put
  // n pulses on pin 1, pin 2 held at the direction level
  task automatic pulses(input int n, input logic lvl, input int hi, input int lo);
    repeat (n) begin
      put(1'b1, lvl, hi);
      put(1'b0, lvl, lo);
    end
  endtask : pulses
  // fwd steps 10,11,01,00; otherwise 01,11,10,00
  task automatic quad(input int n, input logic fwd, input int half);
    repeat (n) begin
      put(fwd, !fwd, half);
      put(1'b1, 1'b1, half);
      put(!fwd, fwd, half);
      put(1'b0, 1'b0, half);
    end
  endtask : quad
endmodule : pft_sensor

/* dv/testbench.sv */
// Purpose: self-checking bench of the pulse flow totalizer
// Assumes: CLK_HZ shortened to 10000, so one second is 10000 cycles
// Notes: expected totals and rates follow from the pulses sent
`timescale 1ns/1ps
`include "pft_regs.svh"
bind pft_top pft_properties #(.CLK_HZ(CLK_HZ)) u_props (.core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .cnt_in1_i(cnt_in1_i), .cnt_in2_i(cnt_in2_i),
  .rst_src_val_i(rst_src_val_i), .strobe_src_val_i(strobe_src_val_i),
  .dir_src_val_i(dir_src_val_i), .rate_o(rate_o), .total_o(total_o), .lo_o(lo_o),
  .hi_o(hi_o), .irq_o(irq_o));
module testbench;
  import pft_pkg::*;
  localparam int unsigned HZ = 10000;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  pft_addr_t paddr_i = '0;
  pft_word_t pwdata_i = '0;
  pft_word_t rsv = '0;
  pft_word_t stv = '0;
  pft_word_t dsv = '0;
  logic pready_o, pslverr_o, lo_o, hi_o, irq_o, in1, in2;
  pft_word_t prdata_o, rate_o, total_o, rd;
  int n_errors = 0;
  int n_compared = 0;
  int lim[8] = '{10, 25, 50, 100, 1000, 5000, 10000, 50000};
  always #10 core_clk_i = ~core_clk_i;
  pft_sensor u_sen (.core_clk_i(core_clk_i), .cnt_in1_o(in1), .cnt_in2_o(in2));
  pft_top #(.CLK_HZ(HZ)) u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .cnt_in1_i(in1), .cnt_in2_i(in2), .rst_src_val_i(rsv), .strobe_src_val_i(stv),
    .dir_src_val_i(dsv), .rate_o(rate_o), .total_o(total_o), .lo_o(lo_o), .hi_o(hi_o),
    .irq_o(irq_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input pft_word_t got, input pft_word_t exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input pft_addr_t a, input pft_word_t d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    if (n >= 20) chk(32'h0, 32'h1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic rchk(input pft_addr_t a, input pft_word_t exp);
    apb(1'b0, a, '0);
    chk(rd, exp);
  endtask : rchk
  task automatic summarize();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (90000) @(posedge core_clk_i);
    n_errors++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int mc;
    repeat (6) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rchk(a[7:0], 32'h0);
    rchk(8'h24, 32'h0);
    chk({31'h0, pslverr_o}, 32'h1);
    u_sen.pulses(5, 1'b0, 1, 1);
    u_sen.pulses(3, 1'b1, 1, 1);
    u_sen.put(1'b0, 1'b0, 4);
    rchk(`PFT_OFF_TOTAL, 32'h2);
    apb(1'b1, `PFT_OFF_CTRL, 32'h1);
    u_sen.quad(4, 1'b0, 2);
    u_sen.quad(1, 1'b1, 2);
    rchk(`PFT_OFF_TOTAL, 32'h5);
    apb(1'b1, `PFT_OFF_CTRL, 32'h3);
    u_sen.quad(2, 1'b1, 1);
    u_sen.quad(1, 1'b0, 1);
    u_sen.put(1'b0, 1'b0, 4);
    rchk(`PFT_OFF_TOTAL, 32'h1);
    apb(1'b1, `PFT_OFF_CMD, 32'h1);
    apb(1'b0, `PFT_OFF_STS, '0);
    chk({31'h0, rd[`PFT_STS_CLR]}, 32'h1);
    chk(total_o, 32'h0);
    foreach (lim[i]) begin
      mc = (HZ + 2 * lim[i] - 1) / (2 * lim[i]);
      apb(1'b1, `PFT_OFF_CTRL, pft_word_t'((i + 1) << 2));
      if (mc > 1) u_sen.pulses(1, 1'b0, mc - 1, mc + 4);
      u_sen.pulses(1, 1'b0, mc + 2, mc + 4);
      repeat (mc + 8) @(posedge core_clk_i);
      chk(total_o, pft_word_t'(i + 1));
    end
    apb(1'b1, `PFT_OFF_CTRL, 32'h0);
    repeat (1100) @(posedge core_clk_i);
    apb(1'b1, `PFT_OFF_MASK, 32'h3);
    apb(1'b1, `PFT_OFF_STS, 32'hF);
    apb(1'b1, `PFT_OFF_LOW, 32'd300);
    apb(1'b1, `PFT_OFF_HIGH, 32'd500);
    chk({31'h0, irq_o}, 32'h1);
    apb(1'b1, `PFT_OFF_STS, 32'h1);
    repeat (2) @(posedge core_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    fork
      u_sen.pulses(840, 1'b0, 25, 25);
    join_none
    repeat (20100) @(posedge core_clk_i);
    chk(rate_o, 32'd200);
    chk({31'h0, lo_o}, 32'h1);
    apb(1'b1, `PFT_OFF_CTRL, 32'h100);
    repeat (10100) @(posedge core_clk_i);
    chk(rate_o, 32'd12000);
    chk({30'h0, hi_o, irq_o}, 32'h3);
    apb(1'b1, `PFT_OFF_CTRL, 32'h200);
    repeat (10100) @(posedge core_clk_i);
    chk(rate_o, 32'd720000);
    // long enough for the pins to idle past the checker's zero limit
    repeat (3400) @(posedge core_clk_i);
    chk(total_o, 32'd848);
    chk(rate_o, 32'h0);
    apb(1'b0, `PFT_OFF_STS, '0);
    chk({31'h0, rd[`PFT_STS_ZERO]}, 32'h1);
    apb(1'b1, `PFT_OFF_CMD, 32'h1);
    apb(1'b1, `PFT_OFF_CTRL, 32'h1000);
    dsv <= 32'h1;
    u_sen.pulses(3, 1'b0, 2, 2);
    dsv <= 32'hFFFFFFFF;
    u_sen.pulses(2, 1'b0, 2, 2);
    rchk(`PFT_OFF_TOTAL, 32'hFFFFFFFF);
    apb(1'b1, `PFT_OFF_CTRL, 32'h800);
    u_sen.pulses(4, 1'b0, 2, 2);
    rchk(`PFT_OFF_TOTAL, 32'hFFFFFFFF);
    stv <= 32'h1;
    u_sen.pulses(2, 1'b0, 2, 2);
    rchk(`PFT_OFF_TOTAL, 32'h1);
    // unused mode code counts nothing
    apb(1'b1, `PFT_OFF_CTRL, 32'h2);
    u_sen.pulses(2, 1'b0, 2, 2);
    rchk(`PFT_OFF_TOTAL, 32'h1);
    apb(1'b1, `PFT_OFF_CTRL, 32'hC00);
    rchk(`PFT_OFF_TOTAL, 32'h1);
    rsv <= 32'h1;
    rchk(`PFT_OFF_TOTAL, 32'h0);
    summarize();
  end
endmodule : testbench
